// File: dv/csd_chip_select_tb.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got); \
    end \
  end
module csd_chip_select_tb
  import csd_pkg::*;
();
  localparam logic [7:0] STRAP = 8'h05;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic reset_input_n = 1'b0;
  logic [7:0] strap_data;
  csd_xfer_t xfer = '0;
  logic [15:0] cs0_base = 16'h1000;
  logic [15:0] cs0_mask = 16'h0000;
  logic [15:0] cs1_base = 16'h2000;
  logic [15:0] cs1_mask = 16'h00ff;
  logic [7:0] shared_base = 8'h40;
  logic cs0_programmed = 1'b0;
  csd_cfg_t [7:0] cs_cfg;
  csd_out_t bus_out;
  logic [7:0] oe_edge_bad;
  logic boot = 1'b1;
  logic ext = 1'b0;
  int n_errors = 0;
  int num_checks = 0;

  always #2 core_clk = ~core_clk;

  csd_chip_select u_csd_chip_select (.core_clk(core_clk),
    .reset_n(reset_n), .reset_input_n(reset_input_n),
    .strap_data(strap_data), .xfer(xfer), .cs0_base(cs0_base),
    .cs0_mask(cs0_mask), .cs1_base(cs1_base), .cs1_mask(cs1_mask),
    .shared_base(shared_base), .cs0_programmed(cs0_programmed),
    .cs_cfg(cs_cfg), .bus_out(bus_out));

  csd_mem_model #(.STRAP(STRAP)) u_csd_mem_model (.core_clk(core_clk),
    .cs_n(bus_out.cs_n), .oe_n(bus_out.oe_n), .strap_data(strap_data),
    .oe_edge_bad(oe_edge_bad));

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  // Holds one transfer until the registered answer and the strobe settle.
  task automatic run(input logic [31:0] a, input csd_size_t sz,
    input logic rd, input int k, input logic [3:0] ln);
    logic [7:0] ecs;
    logic wl;
    @(posedge core_clk);
    // Settings are read only now, after the caller's updates have landed.
    ecs = (k < 8) ? ~(8'h01 << k) : CSD_CS_ALL_OFF;
    wl = (k < 8) ? (cs_cfg[k].write_mode && !rd) : 1'b0;
    xfer <= '{valid: 1'b1, read: rd, external: ext, addr: a, size: sz};
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    #1;
    `CHK("cs_n", ecs, bus_out.cs_n)
    `CHK("hit", k < 8, bus_out.hit)
    `CHK("oe_n", ~(rd && k < 8), bus_out.oe_n)
    `CHK("lane_enable_n", wl ? 4'hf : ln, bus_out.lane_enable_n)
    `CHK("lane_write_enable_n", wl ? ln : 4'hf,
         bus_out.lane_write_enable_n)
    if (k < 8) begin
      `CHK("wait", boot ? 4'hf : cs_cfg[k].wait_states,
           bus_out.wait_states)
      `CHK("auto_ack", boot ? STRAP[2] : cs_cfg[k].auto_ack,
           bus_out.auto_ack)
    end
    @(posedge core_clk);
    xfer <= '0;
  endtask : run

  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    conclude();
  end

  initial begin
    for (int k = 0; k < 8; k++) begin
      cs_cfg[k] <= '{1'b1, 1'b0, CSD_PS_32, 1'b0, k[0], k[3:0]};
    end
    repeat (5) @(posedge core_clk);
    `CHK("reset cs_n", CSD_CS_ALL_OFF, bus_out.cs_n)
    `CHK("reset oe_n", 1'b1, bus_out.oe_n)
    reset_n <= 1'b1;
    reset_input_n <= 1'b1;
    repeat (5) @(posedge core_clk);
    run(32'h8000_0003, CSD_SZ_BYTE, 1'b1, 0, CSD_LANE_B0);
    run(32'h0000_0002, CSD_SZ_LONG, 1'b1, 0, CSD_LANE_B0);
    cs0_programmed <= 1'b1;
    boot = 1'b0;
    run(32'h1000_fffc, CSD_SZ_LONG, 1'b1, 0, CSD_LANES_ALL);
    run(32'h1001_0000, CSD_SZ_LONG, 1'b1, 8, CSD_LANES_OFF);
    run(32'h20ff_0000, CSD_SZ_WORD, 1'b1, 1, CSD_LANE_16);
    cs1_mask <= 16'hffff;
    run(32'ha000_0000, CSD_SZ_LONG, 1'b1, 8, CSD_LANES_OFF);
    ext = 1'b1;
    run(32'h7fff_0000, CSD_SZ_LONG, 1'b1, 1, CSD_LANES_ALL);
    ext = 1'b0;
    cs_cfg[1].enable <= 1'b0;
    run(32'h2000_0000, CSD_SZ_LONG, 1'b1, 8, CSD_LANES_OFF);
    for (int k = 2; k < 8; k++) begin
      run({8'h40, k[2:0], 21'h1f_fffc}, CSD_SZ_LONG, 1'b1, k,
          CSD_LANES_ALL);
    end
    run(32'h4020_0000, CSD_SZ_LONG, 1'b1, 8, CSD_LANES_OFF);
    for (int p = 0; p < 4; p++) begin
      for (int b = 0; b < 4; b++) begin
        cs_cfg[2].port_size <= csd_port_t'(p);
        cs_cfg[2].burst <= b[1];
        run(32'h4040_0000 | 32'(b), CSD_SZ_BYTE, 1'b1, 2,
            p == 0 ? ~(4'h1 << b) : p == 1 ? CSD_LANE_B0
            : ~(4'h1 << b % 2));
      end
    end
    cs_cfg[2].port_size <= CSD_PS_16;
    run(32'h4040_0002, CSD_SZ_WORD, 1'b1, 2, CSD_LANE_16);
    cs_cfg[2].port_size <= CSD_PS_32;
    run(32'h4040_0002, CSD_SZ_WORD, 1'b1, 2, CSD_LANE_32);
    run(32'h4040_0000, CSD_SZ_LINE, 1'b1, 2, CSD_LANES_ALL);
    cs_cfg[2].write_mode <= 1'b1;
    run(32'h4040_0001, CSD_SZ_BYTE, 1'b0, 2, CSD_LANE_B1);
    `CHK("oe edge", 8'h00, oe_edge_bad)
    conclude();
  end
endmodule : csd_chip_select_tb

// File: dv/csd_mem_model.sv
`timescale 1ns/1ps
module csd_mem_model
  import csd_pkg::*;
#(
  parameter logic [7:0] STRAP = 8'h05
)
(
  input wire logic core_clk,
  input wire logic [7:0] cs_n,
  input wire logic oe_n,
  output logic [7:0] strap_data,
  output logic [7:0] oe_edge_bad
);
  // Resistor straps hold the boot settings on the data lines.
  logic [7:0] bad_count = 8'h00;
  assign strap_data = STRAP;
  assign oe_edge_bad = bad_count;
  // A memory sees a strobe move with the clock high, or a read unselected.
  always @(oe_n) begin
    if (core_clk === 1'b1 || (oe_n === 1'b0 && cs_n === 8'hff)) begin
      bad_count <= bad_count + 8'h01;
    end
  end
endmodule : csd_mem_model

// File: rtl/csd_chip_select.sv
`timescale 1ns/1ps
// Function
// R01 - Eight selects: two with own bases, six offset from a shared base.
// R02 - The two independent selects mask address for 64K to 2G blocks.
// R03 - Each shared-base select decodes a fixed 2M block, no masking.
// R04 - Reset disables every select except the first; code forces global mode, where select 0 wins, and never clears cs_cfg enables.
// R05 - After reset the first select matches any address.
// R06 - Port size and termination of the first select latched from D[7:0].
// R07 - Read output-enable changes only on falling clock edges.
// R08 - Output-enable asserts only when an enabled select matches.
// R09 - Each lane acts as byte or write enable, chosen per select.
// R10 - Lanes come from size, A1, A0, port size and burst of the match.
// R11 - Byte to 8-bit port asserts only the D[31:24] lane.
// R12 - Byte to 16-bit port picks D[31:24] or D[23:16] by A0.
// R13 - Byte to 32-bit port asserts exactly one lane chosen by A1A0.
// R14 - Each select has port size, burst, wait states, termination choice.
// R15 - External master cycles are decoded like internal ones.
// R16 - Longword or line to a 32-bit port asserts all four lanes.
module csd_chip_select
  import csd_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic reset_input_n,
  input wire logic [7:0] strap_data,
  input wire csd_xfer_t xfer,
  input wire logic [15:0] cs0_base,
  input wire logic [15:0] cs0_mask,
  input wire logic [15:0] cs1_base,
  input wire logic [15:0] cs1_mask,
  input wire logic [7:0] shared_base,
  input wire logic cs0_programmed,
  input wire csd_cfg_t [7:0] cs_cfg,
  output csd_out_t bus_out
);

  typedef struct packed {
    logic [1:0] rst_sync;
    logic reset_input_n_seen;
    logic global_mode;
    csd_port_t boot_port;
    logic boot_auto_ack;
    csd_out_t out;
  } csd_state_t;

  localparam csd_out_t CSD_OUT_IDLE = '{cs_n: CSD_CS_ALL_OFF, oe_n: 1'b1,
    lane_enable_n: CSD_LANES_OFF, lane_write_enable_n: CSD_LANES_OFF,
    wait_states: 4'h0, auto_ack: 1'b0, hit: 1'b0};
  localparam csd_state_t CSD_STATE_RESET = '{rst_sync: 2'h0,
    reset_input_n_seen: 1'b0, global_mode: 1'b1, boot_port: CSD_PS_32,
    boot_auto_ack: 1'b0, out: CSD_OUT_IDLE};

  csd_state_t state_reg;
  csd_state_t state_next;
  logic oe_n_reg;
  logic oe_n_next;
  logic rst_n;
  logic [7:0] match;
  csd_cfg_t sel_cfg;
  logic [3:0] lanes_n;
  logic any_hit;
  logic [2:0] hit_idx;

  // The second stage of the release chain gates the rest of state_reg, not oe_n_reg.
  assign rst_n = state_reg.rst_sync[1];

  function automatic logic ind_match(input logic [15:0] a,
                                     input logic [15:0] base,
                                     input logic [15:0] mask);
    logic [15:0] m;
    m = mask & CSD_MASK_LIMIT;
    return ((a & ~m) == (base & ~m)); // [R02]
  endfunction : ind_match

  always_comb begin
    logic [15:0] ahi;
    ahi = xfer.addr[CSD_IND_LSB +: CSD_IND_W];
    match = '0;
    // Internal and external master cycles use the same decode. [R15]
    match[0] = state_reg.global_mode ||
               ind_match(ahi, cs0_base, cs0_mask); // [R05] [R01]
    match[1] = ind_match(ahi, cs1_base, cs1_mask);
    for (int i = 2; i < CSD_NUM_CS; i++) begin
      match[i] = (xfer.addr[CSD_SHR_BASE_LSB +: CSD_SHR_BASE_W] ==
                  shared_base) &&
                 (xfer.addr[CSD_SHR_BLK_LSB +: CSD_SHR_BLK_W] ==
                  3'(i - 2) + CSD_SHR_FIRST_BLK); // [R03]
    end
    for (int i = 0; i < CSD_NUM_CS; i++) begin
      match[i] = match[i] &&
                 (i == 0 ? (state_reg.global_mode || cs_cfg[0].enable)
                         : cs_cfg[i].enable); // [R04]
    end
  end

  always_comb begin
    any_hit = 1'b0;
    hit_idx = 3'h0;
    for (int i = CSD_NUM_CS - 1; i >= 0; i--) begin
      if (match[i]) begin
        any_hit = 1'b1;
        hit_idx = 3'(i);
      end
    end
    sel_cfg = cs_cfg[hit_idx];
    if (hit_idx == 3'h0 && state_reg.global_mode) begin
      sel_cfg.port_size = state_reg.boot_port; // [R06]
      sel_cfg.auto_ack = state_reg.boot_auto_ack;
      sel_cfg.write_mode = 1'b0;
      sel_cfg.burst = 1'b0;
      sel_cfg.wait_states = '1;
    end
  end

  csd_lane_decode u_lane (
    .transfer_size(xfer.size),
    .addr_low(xfer.addr[1:0]),
    .port_size(sel_cfg.port_size),
    .burst(sel_cfg.burst),
    .lanes_n(lanes_n)
  ); // [R10]

  always_comb begin
    state_next = state_reg;
    state_next.rst_sync = {state_reg.rst_sync[0], 1'b1};
    state_next.reset_input_n_seen = reset_input_n;
    if (reset_input_n && !state_reg.reset_input_n_seen) begin
      state_next.boot_port = csd_port_t'(strap_data[CSD_STRAP_PS_LSB +: 2]);
      state_next.boot_auto_ack = strap_data[CSD_STRAP_AA_BIT]; // [R06]
    end
    if (cs0_programmed) begin
      state_next.global_mode = 1'b0;
    end
    state_next.out.cs_n = CSD_CS_ALL_OFF;
    state_next.out.lane_enable_n = CSD_LANES_OFF;
    state_next.out.lane_write_enable_n = CSD_LANES_OFF;
    state_next.out.hit = 1'b0;
    state_next.out.oe_n = 1'b1;
    state_next.out.wait_states = sel_cfg.wait_states; // [R14]
    state_next.out.auto_ack = sel_cfg.auto_ack;
    if (xfer.valid && any_hit) begin
      state_next.out.hit = 1'b1;
      state_next.out.cs_n[hit_idx] = 1'b0;
      state_next.out.oe_n = !xfer.read; // [R08]
      if (sel_cfg.write_mode) begin
        if (!xfer.read) begin
          state_next.out.lane_write_enable_n = lanes_n; // [R09]
        end
      end else begin
        state_next.out.lane_enable_n = lanes_n; // [R09]
      end
    end
    // Until the release chain settles, hold the boot state and outputs.
    if (!rst_n) begin
      state_next = state_reg;
      state_next.rst_sync = {state_reg.rst_sync[0], 1'b1};
      state_next.reset_input_n_seen = 1'b0;
      state_next.global_mode = 1'b1; // [R04]
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= CSD_STATE_RESET; // [R05]
    end else begin
      state_reg <= state_next;
    end
  end

  // The read strobe is retimed to the falling edge of the clock.
  assign oe_n_next = state_reg.out.oe_n;
  always_ff @(negedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      oe_n_reg <= 1'b1;
    end else begin
      oe_n_reg <= oe_n_next; // [R07]
    end
  end

  always_comb begin
    bus_out = state_reg.out;
    bus_out.oe_n = oe_n_reg;
  end

  a_oe_needs_hit: assert property ( // [R08]
    @(negedge core_clk) disable iff (!rst_n)
    !oe_n_reg |-> $past(state_reg.out.hit))
    else $error("read strobe without a select match");
  a_cs_onehot: assert property ( // [R01]
    @(posedge core_clk) disable iff (!rst_n)
    $countones(~state_reg.out.cs_n) <= 1)
    else $error("more than one select active");
  a_cs0_global: assert property ( // [R05]
    @(posedge core_clk) disable iff (!rst_n)
    (state_reg.global_mode && xfer.valid) |=> !state_reg.out.cs_n[0])
    else $error("first select missed in global mode");
  a_byte_one_lane: assert property ( // [R13]
    @(posedge core_clk) disable iff (!rst_n)
    (xfer.valid && any_hit && xfer.size == CSD_SZ_BYTE) |->
    $countones(~lanes_n) == 1)
    else $error("byte transfer did not pick exactly one lane");
  a_port8_lane: assert property ( // [R11]
    @(posedge core_clk) disable iff (!rst_n)
    (sel_cfg.port_size == CSD_PS_8) |-> lanes_n == CSD_LANE_B0)
    else $error("8-bit port used another lane");
  a_long_all: assert property ( // [R16]
    @(posedge core_clk) disable iff (!rst_n)
    (sel_cfg.port_size == CSD_PS_32 && (xfer.size == CSD_SZ_LONG ||
     xfer.size == CSD_SZ_LINE)) |-> lanes_n == CSD_LANES_ALL)
    else $error("long transfer on 32-bit port missed lanes");
  a_port16_lane: assert property ( // [R12]
    @(posedge core_clk) disable iff (!rst_n)
    (sel_cfg.port_size == CSD_PS_16 && xfer.size == CSD_SZ_BYTE) |->
    lanes_n == (xfer.addr[0] ? CSD_LANE_B1 : CSD_LANE_B0))
    else $error("16-bit byte lane wrong");
  a_disabled_quiet: assert property ( // [R04]
    @(posedge core_clk) disable iff (!rst_n)
    (xfer.valid && !cs_cfg[1].enable) |=> state_reg.out.cs_n[1])
    else $error("disabled select asserted");
  a_oe_follows: assert property ( // [R07]
    @(posedge core_clk) disable iff (!rst_n)
    oe_n_reg == state_reg.out.oe_n)
    else $error("read strobe not retimed on the falling edge");
  a_write_no_oe: assert property ( // [R08]
    @(posedge core_clk) disable iff (!rst_n)
    (xfer.valid && !xfer.read) |=> state_reg.out.oe_n)
    else $error("read strobe raised on a write");
  a_shared_block: assert property ( // [R03]
    @(posedge core_clk) disable iff (!rst_n)
    (xfer.valid && any_hit && hit_idx >= CSD_SHR_FIRST_BLK) |->
    xfer.addr[CSD_SHR_BLK_LSB +: CSD_SHR_BLK_W] == hit_idx)
    else $error("shared select hit outside its fixed block");

endmodule : csd_chip_select

// File: rtl/csd_lane_decode.sv
`timescale 1ns/1ps
module csd_lane_decode
  import csd_pkg::*;
(
  input wire csd_size_t transfer_size,
  input wire logic [1:0] addr_low,
  input wire csd_port_t port_size,
  input wire logic burst,
  output logic [3:0] lanes_n
);

  // Burst capability leaves the pattern unchanged for every listed case.
  logic burst_unused;
  assign burst_unused = burst;

  always_comb begin
    lanes_n = CSD_LANES_OFF;
    if (port_size == CSD_PS_8) begin
      lanes_n = CSD_LANE_B0; // [R11]
    end else if (port_size == CSD_PS_16 || port_size == CSD_PS_16B) begin
      if (transfer_size == CSD_SZ_BYTE) begin
        lanes_n = addr_low[0] ? CSD_LANE_B1 : CSD_LANE_B0; // [R12]
      end else begin
        lanes_n = CSD_LANE_16;
      end
    end else begin
      case (transfer_size)
        // Lane 0 carries D[31:24], so A1A0 counts lanes upward from it.
        CSD_SZ_BYTE: lanes_n = ~(~CSD_LANE_B0 << addr_low); // [R13]
        CSD_SZ_WORD: lanes_n = addr_low[1] ? CSD_LANE_32 : CSD_LANE_16;
        default: lanes_n = CSD_LANES_ALL; // [R16]
      endcase
    end
  end

endmodule : csd_lane_decode

// File: rtl/csd_pkg.sv
package csd_pkg;

  localparam int CSD_NUM_CS = 8;
  localparam int CSD_NUM_LANES = 4;

  // Independent selects match address bits [31:16] under a mask, 64K to 2G.
  localparam int CSD_IND_LSB = 16;
  localparam int CSD_IND_W = 16;
  // Shared-base selects: 8-bit base on [31:24], 2M block index on [23:21].
  localparam int CSD_SHR_BASE_LSB = 24;
  localparam int CSD_SHR_BASE_W = 8;
  localparam int CSD_SHR_BLK_LSB = 21;
  localparam int CSD_SHR_BLK_W = 3;
  localparam logic [2:0] CSD_SHR_FIRST_BLK = 3'h2;
  // The 2G ceiling means the mask may never cover address bit 31.
  localparam logic [15:0] CSD_MASK_LIMIT = 16'h7fff;

  localparam logic [7:0] CSD_CS_RESET_EN = 8'h01;
  localparam logic [7:0] CSD_CS_ALL_OFF = 8'hff;
  localparam logic [3:0] CSD_LANES_OFF = 4'hf;
  localparam logic [3:0] CSD_LANES_ALL = 4'h0;
  localparam logic [3:0] CSD_LANE_B0 = 4'he;
  localparam logic [3:0] CSD_LANE_B1 = 4'hd;
  localparam logic [3:0] CSD_LANE_16 = 4'hc;
  localparam logic [3:0] CSD_LANE_32 = 4'h3;

  // Strap fields sampled on D[7:0] when the reset input deasserts.
  localparam int CSD_STRAP_PS_LSB = 0;
  localparam int CSD_STRAP_AA_BIT = 2;

  typedef enum logic [1:0] {
    CSD_SZ_LONG = 2'h0,
    CSD_SZ_BYTE = 2'h1,
    CSD_SZ_WORD = 2'h2,
    CSD_SZ_LINE = 2'h3
  } csd_size_t;

  typedef enum logic [1:0] {
    CSD_PS_32 = 2'h0,
    CSD_PS_8 = 2'h1,
    CSD_PS_16 = 2'h2,
    CSD_PS_16B = 2'h3
  } csd_port_t;

  typedef struct packed {
    logic enable;
    logic write_mode;
    csd_port_t port_size;
    logic burst;
    logic auto_ack;
    logic [3:0] wait_states;
  } csd_cfg_t;

  typedef struct packed {
    logic valid;
    logic read;
    logic external;
    logic [31:0] addr;
    csd_size_t size;
  } csd_xfer_t;

  typedef struct packed {
    logic [7:0] cs_n;
    logic oe_n;
    logic [3:0] lane_enable_n;
    logic [3:0] lane_write_enable_n;
    logic [3:0] wait_states;
    logic auto_ack;
    logic hit;
  } csd_out_t;

endpackage : csd_pkg
